// ### core/dgp_port_top.sv
// Two general purpose ports with peripheral sharing and parallel mode
// How it works
// RULE1: First port: eight pins, own direction bits
// RULE2: Direction one floats pin, zero drives latch
// RULE3: Enabled peripheral overrides first-port pin direction
// RULE4: Override lasts only while peripheral enabled
// RULE5: Software avoids bit operations on overridden direction
// RULE6: Select chooses latch or peripheral output data
// RULE7: Peripheral enable acts only while selected
// RULE8: Data latches untouched by reset
// RULE9: Bit 0: I/O, timer oscillator out, clock in
// RULE10: Bit 1: I/O, oscillator in, second CCP
// RULE11: Bit 2: I/O or first CCP
// RULE12: Bit 3: serial port clock, SPI and I2C
// RULE13: Bit 4: SPI data in, I2C data
// RULE14: Bit 5: I/O or serial data out
// RULE15: Bit 6: I/O, USART transmit or clock
// RULE16: Bit 7: I/O, USART receive or data
// RULE17: Second port: eight pins, own direction bits
// RULE18: Mode bit makes second port parallel port
// RULE19: Parallel bit n on second-port pin n
// RULE20: Control register resets to 0000 -111
// RULE21: Data read gives pins, write sets latch
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
`include "dgp_defines.svh"
module dgp_port_top
  import dgp_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // First port pins
  input  wire logic [7:0] i_first_pin,
  output logic      [7:0] o_first_out,
  output logic      [7:0] o_first_oe,
  // Second port pins
  input  wire logic [7:0] i_second_pin,
  output logic      [7:0] o_second_out,
  output logic      [7:0] o_second_oe,
  // Synchronised pin levels for peripherals and the parallel port
  output logic      [7:0] o_first_level,
  output logic      [7:0] o_parallel_data,
  // Secondary timer
  input  wire logic       i_tmr_osc_en,
  input  wire logic       i_tmr_osc_drive,
  input  wire logic       i_tmr_ext_clk_en,
  // Capture/compare/PWM units
  input  wire logic       i_pwm1_en,
  input  wire logic       i_pwm1_oe,
  input  wire logic       i_pwm1_out,
  input  wire logic       i_pwm2_en,
  input  wire logic       i_pwm2_oe,
  input  wire logic       i_pwm2_out,
  // Synchronous serial port
  input  wire logic       i_ssp_en,
  input  wire logic       i_ssp_i2c,
  input  wire logic       i_ssp_sck_oe,
  input  wire logic       i_ssp_sck_out,
  input  wire logic       i_ssp_sda_oe,
  input  wire logic       i_ssp_sda_out,
  input  wire logic       i_ssp_sdo_out,
  // USART
  input  wire logic       i_usart_en,
  input  wire logic       i_usart_sync,
  input  wire logic       i_usart_tx_out,
  input  wire logic       i_usart_ck_oe,
  input  wire logic       i_usart_ck_out,
  input  wire logic       i_usart_dt_oe,
  input  wire logic       i_usart_dt_out,
  // Parallel slave handshake (outside this block)
  input  wire logic       i_psp_drive,
  input  wire logic       i_input_buffer_full_flag,
  input  wire logic       i_output_buffer_full_flag,
  input  wire logic       i_input_overflow_flag,
  output logic            o_parallel_slave_mode_bit,
  output logic      [2:0] o_third_port_dir
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check

  if (WIDTH != 8)
  begin : g_width_check
    $error("dgp_port_top: WIDTH must be 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Register decode, shared by read and write paths
  function automatic dgp_reg_t decode(input logic [7:0] addr);
    dgp_reg_t r;
    r = DGP_REG_NONE;
    unique case (addr)
      `DGP_OFS_FIRST_DATA:  r = DGP_REG_FIRST_DATA;
      `DGP_OFS_SECOND_DATA: r = DGP_REG_SECOND_DATA;
      `DGP_OFS_FIRST_DIR:   r = DGP_REG_FIRST_DIR;
      `DGP_OFS_SECOND_DIR:  r = DGP_REG_SECOND_DIR;
      `DGP_OFS_PAR_CTRL:    r = DGP_REG_PAR_CTRL;
      default:              r = DGP_REG_NONE;
    endcase
    return r;
  endfunction

  // Filtered level: take a change once stages two and three agree
  function automatic logic [7:0] settle(input logic [7:0] s2,
                                        input logic [7:0] s3,
                                        input logic [7:0] old);
    logic [7:0] v;
    v = old;
    for (int i = 0; i < 8; i++)
    begin
      if (s2[i] == s3[i])
      begin
        v[i] = s3[i];
      end
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers

  logic [7:0] first_s1_q;
  logic [7:0] first_s2_q;
  logic [7:0] first_s3_q;
  logic [7:0] first_lvl_q;
  logic [7:0] second_s1_q;
  logic [7:0] second_s2_q;
  logic [7:0] second_s3_q;
  logic [7:0] second_lvl_q;

  always_ff @(posedge i_clk)
  begin
    first_s1_q   <= i_first_pin;
    first_s2_q   <= first_s1_q;
    first_s3_q   <= first_s2_q;
    second_s1_q  <= i_second_pin;
    second_s2_q  <= second_s1_q;
    second_s3_q  <= second_s2_q;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      first_lvl_q  <= 8'h00;
      second_lvl_q <= 8'h00;
    end
    else
    begin
      first_lvl_q  <= settle(first_s2_q, first_s3_q, first_lvl_q);
      second_lvl_q <= settle(second_s2_q, second_s3_q, second_lvl_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  dgp_reg_t   acc_reg;
  logic       wr_first_data;
  logic       wr_second_data;
  logic       wr_first_dir;
  logic       wr_second_dir;
  logic       wr_ctrl;

  always_comb
  begin
    acc_reg        = decode(i_addr);
    wr_first_data  = i_wr && (acc_reg == DGP_REG_FIRST_DATA);
    wr_second_data = i_wr && (acc_reg == DGP_REG_SECOND_DATA);
    wr_first_dir   = i_wr && (acc_reg == DGP_REG_FIRST_DIR);
    wr_second_dir  = i_wr && (acc_reg == DGP_REG_SECOND_DIR);
    wr_ctrl        = i_wr && (acc_reg == DGP_REG_PAR_CTRL);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output latches: no reset, so contents survive every reset

  logic [7:0] first_latch_q;
  logic [7:0] second_latch_q;

  always_ff @(posedge i_clk)
  begin
    if (wr_first_data)
    begin
      first_latch_q <= i_wdata; // RULE21 RULE8
    end
    if (wr_second_data)
    begin
      second_latch_q <= i_wdata; // RULE21 RULE8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direction and control registers

  logic [7:0] first_dir_q;
  logic [7:0] second_dir_q;
  logic       mode_q;
  logic [2:0] third_dir_q;

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      first_dir_q  <= `DGP_RST_DIR;
      second_dir_q <= `DGP_RST_DIR;
    end
    else
    begin
      if (wr_first_dir)
      begin
        first_dir_q <= i_wdata; // RULE1
      end
      if (wr_second_dir)
      begin
        second_dir_q <= i_wdata; // RULE17
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      mode_q      <= `DGP_RST_CTRL_MODE; // RULE20
      third_dir_q <= `DGP_RST_CTRL_DIR; // RULE20
    end
    else if (wr_ctrl)
    begin
      mode_q      <= i_wdata[`DGP_CTRL_MODE]; // RULE18
      third_dir_q <= i_wdata[`DGP_CTRL_DIR_HI:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // First port: peripheral select, enable and data per pin

  dgp_mux_if  first_m ();
  logic [7:0] c_sel;
  logic [7:0] c_oe;
  logic [7:0] c_out;

  always_comb
  begin
    c_sel = 8'h00;
    c_oe  = 8'h00;
    c_out = 8'h00;
    // Oscillator drives bit 0, external clock only listens on it
    c_sel[0] = i_tmr_osc_en || i_tmr_ext_clk_en; // RULE9
    c_oe[0]  = i_tmr_osc_en; // RULE9
    c_out[0] = i_tmr_osc_drive; // RULE9
    // Oscillator input has priority over the second CCP
    if (i_tmr_osc_en)
    begin
      c_sel[1] = 1'b1; // RULE10
    end
    else if (i_pwm2_en)
    begin
      c_sel[1] = 1'b1; // RULE10
      c_oe[1]  = i_pwm2_oe;
      c_out[1] = i_pwm2_out;
    end
    c_sel[2] = i_pwm1_en; // RULE11
    c_oe[2]  = i_pwm1_oe;
    c_out[2] = i_pwm1_out;
    c_sel[3] = i_ssp_en; // RULE12
    c_oe[3]  = i_ssp_sck_oe;
    c_out[3] = i_ssp_sck_out;
    // SPI data in is input only, I2C data is two-way
    c_sel[4] = i_ssp_en; // RULE13
    c_oe[4]  = i_ssp_i2c && i_ssp_sda_oe; // RULE13
    c_out[4] = i_ssp_i2c && i_ssp_sda_out;
    c_sel[5] = i_ssp_en && !i_ssp_i2c; // RULE14
    c_oe[5]  = 1'b1;
    c_out[5] = i_ssp_sdo_out;
    c_sel[6] = i_usart_en; // RULE15
    c_oe[6]  = i_usart_sync ? i_usart_ck_oe : 1'b1; // RULE15
    c_out[6] = i_usart_sync ? i_usart_ck_out : i_usart_tx_out;
    c_sel[7] = i_usart_en; // RULE16
    c_oe[7]  = i_usart_sync && i_usart_dt_oe; // RULE16
    c_out[7] = i_usart_sync && i_usart_dt_out;
  end

  assign first_m.sel     = c_sel; // RULE3 RULE4
  assign first_m.per_out = c_out;
  assign first_m.per_oe  = c_oe;
  assign first_m.dir     = first_dir_q;
  assign first_m.latch   = first_latch_q;

  dgp_pin_mux u_first_mux
  (
    .m (first_m.mux)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Second port: parallel mode takes every pin

  dgp_mux_if  second_m ();

  assign second_m.sel     = {8{mode_q}}; // RULE18 RULE19
  assign second_m.per_out = second_latch_q; // RULE19
  assign second_m.per_oe  = {8{i_psp_drive}};
  assign second_m.dir     = second_dir_q;
  assign second_m.latch   = second_latch_q;

  dgp_pin_mux u_second_mux
  (
    .m (second_m.mux)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registered pin drivers and side outputs

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_first_out  <= 8'h00;
      o_first_oe   <= 8'h00;
      o_second_out <= 8'h00;
      o_second_oe  <= 8'h00;
    end
    else
    begin
      o_first_out  <= first_m.pin_out; // RULE6
      o_first_oe   <= first_m.pin_oe; // RULE2 RULE7
      o_second_out <= second_m.pin_out;
      o_second_oe  <= second_m.pin_oe; // RULE2
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_first_level             <= 8'h00;
      o_parallel_data           <= 8'h00;
      o_parallel_slave_mode_bit <= `DGP_RST_CTRL_MODE;
      o_third_port_dir          <= `DGP_RST_CTRL_DIR;
    end
    else
    begin
      o_first_level             <= first_lvl_q;
      o_parallel_data           <= mode_q ? second_lvl_q : 8'h00; // RULE19
      o_parallel_slave_mode_bit <= mode_q;
      o_third_port_dir          <= third_dir_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: data one cycle after the strobe, zero otherwise

  logic [7:0] rdata_d;

  always_comb
  begin
    rdata_d = `DGP_RDATA_UNMAPPED;
    unique case (acc_reg)
      DGP_REG_FIRST_DATA:  rdata_d = first_lvl_q; // RULE21
      DGP_REG_SECOND_DATA: rdata_d = second_lvl_q; // RULE21
      // Overridden value reads back, hence bit operations misbehave
      DGP_REG_FIRST_DIR:   rdata_d = first_m.eff_dir; // RULE5
      DGP_REG_SECOND_DIR:  rdata_d = second_dir_q;
      DGP_REG_PAR_CTRL:
      begin
        rdata_d[`DGP_CTRL_IN_FULL]  = i_input_buffer_full_flag;
        rdata_d[`DGP_CTRL_OUT_FULL] = i_output_buffer_full_flag;
        rdata_d[`DGP_CTRL_IN_OVF]   = i_input_overflow_flag;
        rdata_d[`DGP_CTRL_MODE]     = mode_q;
        rdata_d[`DGP_CTRL_UNUSED]   = 1'b0; // RULE20
        rdata_d[`DGP_CTRL_DIR_HI:0] = third_dir_q;
      end
      DGP_REG_NONE:        rdata_d = `DGP_RDATA_UNMAPPED;
    endcase
    if (!i_rd)
    begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_rdata <= 8'h00;
    end
    else
    begin
      o_rdata <= rdata_d;
    end
  end

endmodule

// ### pkg/dgp_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef DGP_DEFINES_SVH
`define DGP_DEFINES_SVH

`define DGP_ADDR_W            8
`define DGP_DATA_W            8

`define DGP_OFS_FIRST_DATA    8'h07
`define DGP_OFS_SECOND_DATA   8'h08
`define DGP_OFS_FIRST_DIR     8'h87
`define DGP_OFS_SECOND_DIR    8'h88
`define DGP_OFS_PAR_CTRL      8'h89

`define DGP_RST_DIR           8'hff
`define DGP_RST_CTRL_DIR      3'h7
`define DGP_RST_CTRL_MODE     1'h0

`define DGP_CTRL_IN_FULL      7
`define DGP_CTRL_OUT_FULL     6
`define DGP_CTRL_IN_OVF       5
`define DGP_CTRL_MODE         4
`define DGP_CTRL_UNUSED       3
`define DGP_CTRL_DIR_HI       2

`define DGP_SYNC_STAGES       3
`define DGP_RDATA_UNMAPPED    8'h00

`endif

// ### pkg/dgp_pkg.sv
// Types shared by the port block and its pin multiplexer
package dgp_pkg;

  typedef logic [7:0] dgp_byte_t;

  typedef enum logic [2:0]
  {
    DGP_REG_FIRST_DATA,
    DGP_REG_SECOND_DATA,
    DGP_REG_FIRST_DIR,
    DGP_REG_SECOND_DIR,
    DGP_REG_PAR_CTRL,
    DGP_REG_NONE
  } dgp_reg_t;

endpackage

// ### pkg/dgp_mux_if.sv
// Per-pin selection signals between the port block and a pin multiplexer
`timescale 1ns/10ps
interface dgp_mux_if;
  logic [7:0] sel;
  logic [7:0] per_out;
  logic [7:0] per_oe;
  logic [7:0] dir;
  logic [7:0] latch;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] eff_dir;

  modport port
  (
    output sel,
    output per_out,
    output per_oe,
    output dir,
    output latch,
    input  pin_out,
    input  pin_oe,
    input  eff_dir
  );

  modport mux
  (
    input  sel,
    input  per_out,
    input  per_oe,
    input  dir,
    input  latch,
    output pin_out,
    output pin_oe,
    output eff_dir
  );
endinterface

// ### core/dgp_pin_mux.sv
// Per-pin choice between port latch and peripheral driver
`timescale 1ns/10ps
module dgp_pin_mux
  import dgp_pkg::*;
(
  dgp_mux_if.mux m
);

  ////////////////////////////////////////////////////////////////////////////
  // Data select: latch or peripheral value
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      m.pin_out[i] = m.sel[i] ? m.per_out[i] : m.latch[i]; // RULE6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Driver enable: peripheral enable only counts while selected
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      m.pin_oe[i]  = m.sel[i] ? m.per_oe[i] : ~m.dir[i]; // RULE7 RULE2
      m.eff_dir[i] = m.sel[i] ? ~m.per_oe[i] : m.dir[i]; // RULE3 RULE4
    end
  end

endmodule

// ### bench/dgp_pin_model.sv
// Pad model: each two-way pin shows the block's driver or the outside level
`timescale 1ns/10ps
module dgp_pin_model
  import dgp_pkg::*;
(
  input  wire dgp_byte_t i_out1,
  input  wire dgp_byte_t i_oe1,
  input  wire dgp_byte_t i_ext1,
  input  wire dgp_byte_t i_out2,
  input  wire dgp_byte_t i_oe2,
  input  wire dgp_byte_t i_ext2,
  output dgp_byte_t      o_pin1,
  output dgp_byte_t      o_pin2
);
  // A released pad follows whatever the outside world drives
  assign o_pin1 = (i_oe1 & i_out1) | (~i_oe1 & i_ext1);
  assign o_pin2 = (i_oe2 & i_out2) | (~i_oe2 & i_ext2);
endmodule

// ### bench/dgp_port_top_assertions.sv
// Port-level checker for the dual port block
`timescale 1ns/10ps
module dgp_port_checker
(
  input wire logic       i_clk,
  input wire logic       i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] o_first_out,
  input wire logic [7:0] o_first_oe,
  input wire logic [7:0] o_second_oe,
  input wire logic       o_parallel_slave_mode_bit,
  input wire logic       i_tmr_osc_en,
  input wire logic       i_tmr_osc_drive,
  input wire logic       i_tmr_ext_clk_en,
  input wire logic       i_pwm1_en,
  input wire logic       i_pwm1_oe,
  input wire logic       i_pwm1_out,
  input wire logic       i_pwm2_en,
  input wire logic       i_ssp_en,
  input wire logic       i_ssp_i2c,
  input wire logic       i_ssp_sck_oe,
  input wire logic       i_usart_en,
  input wire logic       i_usart_sync,
  input wire logic       i_usart_tx_out,
  input wire logic       i_psp_drive,
  input wire logic       i_input_buffer_full_flag,
  input wire logic       i_output_buffer_full_flag,
  input wire logic       i_input_overflow_flag
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  wire pe = i_tmr_osc_en | i_tmr_ext_clk_en | i_pwm1_en | i_pwm2_en | i_ssp_en | i_usart_en;
  wire mode = o_parallel_slave_mode_bit;
  ////////////////////////////////////////////////////////////////////////
  sequence s_dir1;
    i_wr && i_addr == 8'h87 && !pe ##1 !(i_wr && i_addr == 8'h87) && !pe;
  endsequence
  sequence s_dir2;
    i_wr && i_addr == 8'h88 ##1 !(i_wr && i_addr == 8'h88) && !mode;
  endsequence
  property p_dir1; s_dir1 |=> o_first_oe == ~$past(i_wdata, 2); endproperty
  property p_dir2; s_dir2 |=> o_second_oe == ~$past(i_wdata, 2); endproperty
  property p_rd_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  property p_unmapped;
    $past(i_rd && i_rstn) && !($past(i_addr) inside {8'h07, 8'h08, 8'h87, 8'h88, 8'h89})
      |-> o_rdata == 8'h00;
  endproperty
  property p_ctrl_rd;
    $past(i_rd && i_rstn) && $past(i_addr) == 8'h89 |-> !o_rdata[3] && o_rdata[7:5] ==
      $past({i_input_buffer_full_flag, i_output_buffer_full_flag, i_input_overflow_flag});
  endproperty
  property p_pwm1;
    $past(i_pwm1_en && i_rstn)
      |-> {o_first_oe[2], o_first_out[2]} == $past({i_pwm1_oe, i_pwm1_out});
  endproperty
  property p_tmr;
    $past(i_tmr_osc_en && !i_tmr_ext_clk_en && i_rstn)
      |-> o_first_oe[1:0] == 2'b01 && o_first_out[0] == $past(i_tmr_osc_drive);
  endproperty
  property p_usart;
    $past(i_usart_en && !i_usart_sync && i_rstn)
      |-> o_first_oe[7:6] == 2'b01 && o_first_out[6] == $past(i_usart_tx_out);
  endproperty
  property p_spi;
    $past(i_ssp_en && !i_ssp_i2c && i_rstn) |-> o_first_oe[4:3] == {1'b0, $past(i_ssp_sck_oe)};
  endproperty
  property p_psp;
    // Mode output lags the internal bit by one edge, just as the drivers do
    mode && $past(i_rstn) |-> o_second_oe == {8{$past(i_psp_drive)}};
  endproperty
  a_dir1: assert property (p_dir1) else $error("first direction not on drivers");
  a_dir2: assert property (p_dir2) else $error("second direction not on drivers");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control status read wrong");
  a_pwm1: assert property (p_pwm1) else $error("unit 1 not on bit 2");
  a_tmr: assert property (p_tmr) else $error("oscillator pins wrong");
  a_usart: assert property (p_usart) else $error("transmit pins wrong");
  a_spi: assert property (p_spi) else $error("serial clock pins wrong");
  a_psp: assert property (p_psp) else $error("parallel drivers wrong");
endmodule
bind dgp_port_top dgp_port_checker i_chk (.i_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .o_first_out, .o_first_oe, .o_second_oe, .o_parallel_slave_mode_bit,
  .i_tmr_osc_en, .i_tmr_osc_drive, .i_tmr_ext_clk_en, .i_pwm1_en, .i_pwm1_oe, .i_pwm1_out,
  .i_pwm2_en, .i_ssp_en, .i_ssp_i2c, .i_ssp_sck_oe, .i_usart_en, .i_usart_sync,
  .i_usart_tx_out, .i_psp_drive, .i_input_buffer_full_flag, .i_output_buffer_full_flag,
  .i_input_overflow_flag);

// ### bench/tb_dual_gpio_port_with_peripheral_mux.sv
// Self-checking bench for the dual port block
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_dual_gpio_port_with_peripheral_mux
  import dgp_pkg::*;
;
  typedef struct {dgp_byte_t a; dgp_byte_t w; dgp_byte_t e;} dgp_row_t;
  typedef struct {logic [26:0] m; dgp_byte_t e;} dgp_per_t;
  logic        i_clk, i_rstn, i_wr, i_rd;
  dgp_byte_t   i_addr, i_wdata, ext1, ext2, d, pin1, pin2;
  dgp_byte_t   o_rdata, o_first_out, o_first_oe, o_second_out, o_second_oe;
  dgp_byte_t   o_first_level, o_parallel_data;
  logic        o_mode;
  logic [2:0]  o_tdir;
  logic [26:0] pv;
  int          n_fail, checked;
  localparam logic [26:0] BASE = 27'h5000000;
  dgp_row_t rows [5] = '{'{8'h87, 8'h5a, 8'h5a}, '{8'h88, 8'hc3, 8'hc3},
    '{8'h89, 8'hff, 8'hb7}, '{8'h89, 8'h02, 8'ha2}, '{8'h8a, 8'h77, 8'h00}};
  dgp_per_t pers [7] = '{'{27'h0000003, 8'h01}, '{27'h00000c0, 8'h02},
    '{27'h0000a00, 8'h28}, '{27'h0002600, 8'h10}, '{27'h0050000, 8'h40},
    '{27'h02b0000, 8'hc0}, '{27'h0000004, 8'h00}};
  dgp_port_top i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_first_pin(pin1),
    .o_first_out(o_first_out), .o_first_oe(o_first_oe), .i_second_pin(pin2),
    .o_second_out(o_second_out), .o_second_oe(o_second_oe), .o_first_level(o_first_level),
    .o_parallel_data(o_parallel_data), .i_tmr_osc_en(pv[0]), .i_tmr_osc_drive(pv[1]),
    .i_tmr_ext_clk_en(pv[2]), .i_pwm1_en(pv[3]), .i_pwm1_oe(pv[4]), .i_pwm1_out(pv[5]),
    .i_pwm2_en(pv[6]), .i_pwm2_oe(pv[7]), .i_pwm2_out(pv[8]), .i_ssp_en(pv[9]),
    .i_ssp_i2c(pv[10]), .i_ssp_sck_oe(pv[11]), .i_ssp_sck_out(pv[12]),
    .i_ssp_sda_oe(pv[13]), .i_ssp_sda_out(pv[14]), .i_ssp_sdo_out(pv[15]),
    .i_usart_en(pv[16]), .i_usart_sync(pv[17]), .i_usart_tx_out(pv[18]),
    .i_usart_ck_oe(pv[19]), .i_usart_ck_out(pv[20]), .i_usart_dt_oe(pv[21]),
    .i_usart_dt_out(pv[22]), .i_psp_drive(pv[23]), .i_input_overflow_flag(pv[24]),
    .i_output_buffer_full_flag(pv[25]), .i_input_buffer_full_flag(pv[26]),
    .o_parallel_slave_mode_bit(o_mode), .o_third_port_dir(o_tdir));
  dgp_pin_model i_pins (.i_out1(o_first_out), .i_oe1(o_first_oe), .i_ext1(ext1),
    .i_out2(o_second_out), .i_oe2(o_second_oe), .i_ext2(ext2), .o_pin1(pin1), .o_pin2(pin2));
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input dgp_byte_t a, input dgp_byte_t w);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= w;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input dgp_byte_t a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic close_out();
    if (n_fail == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial
  begin
    repeat (5000) @(posedge i_clk);
    n_fail++;
    close_out();
  end
  initial
  begin
    {i_rstn, i_wr, i_rd, i_addr, i_wdata} = '0;
    {pv, ext1, ext2} = {BASE, 8'h3c, 8'h69};
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      `CHK(d, rows[i].e)
    end
    // Whole-register direction writes only, never bit operations
    wr(8'h87, 8'h00);
    wr(8'h07, 8'ha5);
    cyc(2);
    `CHK(o_first_out, 8'ha5)
    `CHK(o_first_oe, 8'hff)
    cyc(6);
    rd(8'h07);
    `CHK(d, 8'ha5)
    wr(8'h87, 8'hff);
    cyc(8);
    `CHK(o_first_oe, 8'h00)
    `CHK(o_first_level, 8'h3c)
    rd(8'h07);
    `CHK(d, 8'h3c)
    @(posedge i_clk);
    pv[5:3] <= 3'b111;
    cyc(2);
    rd(8'h87);
    `CHK(d, 8'hfb)
    @(posedge i_clk);
    pv[5:3] <= 3'b000;
    cyc(2);
    rd(8'h87);
    `CHK(d, 8'hff)
    `CHK(o_first_oe, 8'h00)
    foreach (pers[i])
    begin
      @(posedge i_clk);
      pv <= BASE | pers[i].m;
      cyc(3);
      `CHK(o_first_oe, pers[i].e)
    end
    @(posedge i_clk);
    pv <= BASE;
    wr(8'h08, 8'h96);
    wr(8'h89, 8'h10);
    @(posedge i_clk);
    pv[23] <= 1'b1;
    cyc(3);
    `CHK(o_mode, 1'b1)
    `CHK(o_second_oe, 8'hff)
    `CHK(o_second_out, 8'h96)
    @(posedge i_clk);
    pv[23] <= 1'b0;
    cyc(8);
    `CHK(o_parallel_data, 8'h69)
    wr(8'h89, 8'h02);
    wr(8'h87, 8'h00);
    cyc(3);
    `CHK(o_parallel_data, 8'h00)
    `CHK(o_tdir, 3'h2)
    `CHK(o_first_oe, 8'hff)
    @(posedge i_clk);
    i_rstn <= 1'b0;
    cyc(3);
    `CHK(o_first_oe, 8'h00)
    @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(8'h89);
    `CHK(d, 8'ha7)
    `CHK(o_tdir, 3'h7)
    rd(8'h88);
    `CHK(d, 8'hff)
    rd(8'h87);
    `CHK(d, 8'hff)
    cyc(2);
    `CHK(o_first_out, 8'ha5)
    close_out();
  end
endmodule
